// [hw/csps_pkg.sv]
// Package: register map, field layout, resets and limits of the clock block
package csps_pkg;

  // Register byte offsets
  localparam logic [7:0] CSPS_CTRL_OFS = 8'h00;
  localparam logic [7:0] CSPS_PERIOD_OFS = 8'h04;
  localparam logic [7:0] CSPS_DIVIDE_OFS = 8'h08;
  localparam logic [7:0] CSPS_SYNTH_OFS = 8'h0C;
  localparam logic [7:0] CSPS_PHASE_OFS = 8'h10;
  localparam logic [7:0] CSPS_STATUS_OFS = 8'h14;

  // Control field positions
  localparam int CSPS_MODE_LSB = 0;
  localparam int CSPS_FB_BIT = 2;
  localparam int CSPS_RUN_BIT = 3;
  localparam int CSPS_MAXR_BIT = 4;
  localparam int CSPS_D_LSB = 8;
  localparam int CSPS_OVF_BIT = 16;
  localparam int CSPS_RUNNING_BIT = 17;
  localparam int CSPS_BUSY_BIT = 18;

  // Reset values
  localparam logic [15:0] CSPS_PERIOD_RST = 16'h0010;
  localparam logic [4:0] CSPS_DIVIDE_RST = 5'h04;
  localparam logic [7:0] CSPS_M_RST = 8'h01;
  localparam logic [7:0] CSPS_D_RST = 8'h01;
  localparam logic [10:0] CSPS_PHASE_RST = 11'h000;

  // Limits of the divide code (twice the factor) and of the phase setting
  localparam logic [4:0] CSPS_DIV_MIN = 5'h03;
  localparam logic [4:0] CSPS_DIV_HALF_MAX = 5'h10;
  localparam logic [5:0] CSPS_DIV_MAX = 6'h20;
  localparam logic [15:0] CSPS_PERIOD_MIN = 16'h0008;
  localparam logic signed [10:0] CSPS_FRAC_MAX = 11'sh0FF;
  localparam logic signed [10:0] CSPS_DIRECT_MAX = 11'sh3FF;
  localparam int CSPS_FRAC_SHIFT = 8;

  // Delay line: one tap step and line length, in pclk cycles
  localparam logic [15:0] CSPS_TAP_CYCLES = 16'h0001;
  localparam logic [15:0] CSPS_LINE_CYCLES = 16'h0400;

  // Fine phase modes
  typedef enum logic [1:0] {
    CSPS_FIXED,
    CSPS_VAR_CENTRE,
    CSPS_VAR_POSITIVE,
    CSPS_DIRECT
  } csps_mode_t;

endpackage

// [hw/csps_clock_manager.sv]
// Clock manager: synthesised clocks, coarse phases and fine phase adjust
//
// What this block does
// - Divided output divides input by 1.5..8 in halves, 9..16 in wholes.
// - Double-rate output and its inverse run at twice input frequency.
// - Synthesised output runs at input frequency times M divided by D.
// - Synthesised output and its inverse keep a 50/50 duty cycle.
// - With feedback, synth aligns to phase0 every D input cycles.
// - Coarse phases sit a quarter period apart; inverses half cycle away.
// - Coarse phase relation holds without feedback connected.
// - Fine shifting moves all nine outputs together, relations kept.
// - Fixed and variable shift equals setting over 256 times period.
// - Centre and fixed modes accept settings from -255 to +255.
// - Variable-positive mode accepts settings from 0 to +255 only.
// - Direct shift equals setting times one tap step, 0 to 1023.
// - Fixed mode delays feedback path when positive, reference if negative.
// - Fixed mode offset is set once and then stays constant.
// - Centre mode puts zero skew mid-line, half range each side.
// - Positive and direct modes put zero skew at line start.
// - Variable and direct settings step only while request is active.
// - Completion pulses one adjust cycle; user waits before next step.
// - Variable modes start from setting; direct starts from zero.
// - Request at limit still pulses completion, raises overflow, no change.
// - Request, direction and completion all belong to the adjust clock.
`timescale 1ns/1ps

module csps_clock_manager
(
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Phase adjust handshake, foreign clock
  input wire logic adjust_clock,
  input wire logic adjust_request,
  input wire logic adjust_direction,
  output logic adjust_complete,
  // Clock outputs
  output logic phase0_out,
  output logic phase90_out,
  output logic phase180_out,
  output logic phase270_out,
  output logic double_rate_out,
  output logic double_rate_out_inv,
  output logic divided_out,
  output logic synth_out,
  output logic synth_out_inv
);
  import csps_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions

  // Legal divide codes: 3..16 any, 18..32 even only
  function automatic logic div_ok(input logic [4:0] code, input logic top);
    logic ok;
    ok = 1'b0;
    if (top)
      ok = (code == 5'h00);
    else if (code >= CSPS_DIV_MIN && code <= CSPS_DIV_HALF_MAX)
      ok = 1'b1;
    else if (code > CSPS_DIV_HALF_MAX)
      ok = ~code[0];
    return ok;
  endfunction

  // Setting limits per mode
  function automatic logic phase_ok(input logic signed [10:0] ph,
                                    input csps_mode_t md);
    logic ok;
    ok = 1'b0;
    case (md)
      CSPS_FIXED, CSPS_VAR_CENTRE:
        ok = (ph <= CSPS_FRAC_MAX) && (ph >= -CSPS_FRAC_MAX);
      CSPS_VAR_POSITIVE:
        ok = (ph >= 11'sh000) && (ph <= CSPS_FRAC_MAX);
      CSPS_DIRECT:
        ok = (ph >= 11'sh000) && (ph <= CSPS_DIRECT_MAX);
      default:
        ok = 1'b0;
    endcase
    return ok;
  endfunction

  // Shift in pclk cycles for a setting
  function automatic logic signed [17:0] shift_of(
    input logic signed [10:0] ph, input csps_mode_t md,
    input logic [15:0] per);
    logic signed [31:0] prod;
    prod = 32'sh0;
    if (md == CSPS_DIRECT)
      prod = 32'(ph) * $signed({16'h0000, CSPS_TAP_CYCLES});
    else
      prod = (32'(ph) * $signed({16'h0000, per})) >>> CSPS_FRAC_SHIFT;
    return prod[17:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers and state

  csps_mode_t mode;
  logic fb_en;
  logic run;
  logic max_range;
  logic [15:0] period;
  logic [4:0] div_code;
  logic [7:0] mult;
  logic [7:0] divisor;
  logic signed [10:0] phase_init;
  logic signed [10:0] phase;
  logic overflow;
  logic busy;
  logic done_armed;
  logic signed [17:0] applied;
  logic signed [17:0] target;
  logic [15:0] pos;
  logic [1:0] adv;
  logic [20:0] div_cnt;
  logic [23:0] synth_acc;
  logic [7:0] ref_cycles;
  logic adj_clk_s1, adj_clk_s2, adj_clk_s3;
  logic req_s1, req_s2, req_s3;
  logic dir_s1, dir_s2, dir_s3;
  logic wr_en;
  logic start;
  logic adj_edge;
  logic [15:0] q;
  logic [20:0] div_half;
  logic [5:0] div_eff;
  logic [23:0] synth_lim;
  logic signed [10:0] next_phase;
  logic signed [17:0] line_lim;
  logic [31:0] ctrl_wd;

  assign wr_en = psel & penable & pready & pwrite;
  assign q = period >> 2;
  // Code zero stands for 32, the factor 16 that five bits cannot hold
  assign div_eff = {div_code == 5'h00, div_code};
  assign div_half = 21'(q) * 21'(div_eff);
  assign synth_lim = 24'(period) * 24'(divisor);
  assign adj_edge = adj_clk_s2 & ~adj_clk_s3;
  assign ctrl_wd = {27'h0, max_range, run, fb_en, mode};
  assign start = wr_en && paddr == CSPS_CTRL_OFS && pwdata[CSPS_RUN_BIT]
                 && !run;
  assign target = shift_of(phase, mode, period);

  // Delay line reach: centre mode keeps half each side, max range doubles
  always_comb
  begin
    line_lim = 18'(CSPS_LINE_CYCLES);
    if (max_range)
      line_lim = line_lim <<< 1;
    if (mode == CSPS_VAR_CENTRE)
      line_lim = line_lim >>> 1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state so read data comes from a flop

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (psel && penable && !pready)
    begin
      pready <= 1'b1;
      pslverr <= 1'b0;
      case (paddr)
        CSPS_CTRL_OFS: prdata <= ctrl_wd;
        CSPS_PERIOD_OFS: prdata <= {16'h0000, period};
        CSPS_DIVIDE_OFS: prdata <= {26'h0, div_eff};
        CSPS_SYNTH_OFS: prdata <= {16'h0000, divisor, mult};
        CSPS_PHASE_OFS: prdata <= {21'h0, phase_init};
        CSPS_STATUS_OFS:
          prdata <= {13'h0, busy, run, overflow, 5'h00, phase};
        default:
        begin
          prdata <= 32'h0000_0000;
          pslverr <= 1'b1;
        end
      endcase
    end
    else
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Configuration writes; illegal values are dropped, old value kept
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode <= CSPS_FIXED;
      fb_en <= 1'b0;
      run <= 1'b0;
      max_range <= 1'b0;
      period <= CSPS_PERIOD_RST;
      div_code <= CSPS_DIVIDE_RST;
      mult <= CSPS_M_RST;
      divisor <= CSPS_D_RST;
      phase_init <= CSPS_PHASE_RST;
    end
    else if (wr_en)
    begin
      case (paddr)
        CSPS_CTRL_OFS:
        begin
          run <= pwdata[CSPS_RUN_BIT];
          // Mode and steering only change while stopped
          if (!run)
          begin
            mode <= csps_mode_t'(pwdata[CSPS_MODE_LSB +: 2]);
            fb_en <= pwdata[CSPS_FB_BIT];
            max_range <= pwdata[CSPS_MAXR_BIT];
          end
        end
        CSPS_PERIOD_OFS:
          if (!run && pwdata[15:0] >= CSPS_PERIOD_MIN
              && pwdata[1:0] == 2'b00)
            period <= pwdata[15:0];
        CSPS_DIVIDE_OFS:
          if (!run && div_ok(pwdata[4:0], pwdata[5]))
            div_code <= pwdata[4:0];
        CSPS_SYNTH_OFS:
          if (!run && pwdata[7:0] != 8'h00 && pwdata[15:8] != 8'h00)
          begin
            mult <= pwdata[7:0];
            divisor <= pwdata[CSPS_D_LSB +: 8];
          end
        CSPS_PHASE_OFS:
          if (!run && phase_ok(pwdata[10:0], mode))
            phase_init <= pwdata[10:0];
        default:
          phase_init <= phase_init;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Adjust-clock synchronisers and edge detect
  // Request and direction get one flop more than the clock, so the level
  // standing just before each adjust edge is taken, not the one after it

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      adj_clk_s1 <= 1'b0;
      adj_clk_s2 <= 1'b0;
      adj_clk_s3 <= 1'b0;
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      req_s3 <= 1'b0;
      dir_s1 <= 1'b0;
      dir_s2 <= 1'b0;
      dir_s3 <= 1'b0;
    end
    else
    begin
      adj_clk_s1 <= adjust_clock;
      adj_clk_s2 <= adj_clk_s1;
      adj_clk_s3 <= adj_clk_s2;
      req_s1 <= adjust_request;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
      dir_s1 <= adjust_direction;
      dir_s2 <= dir_s1;
      dir_s3 <= dir_s2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Phase setting and step handshake

  // Candidate setting for a step in the sampled direction
  always_comb
  begin
    next_phase = phase;
    if (dir_s3)
      next_phase = phase + 11'sh001;
    else
      next_phase = phase - 11'sh001;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase <= CSPS_PHASE_RST;
      overflow <= 1'b0;
      busy <= 1'b0;
      done_armed <= 1'b0;
      adjust_complete <= 1'b0;
    end
    else if (start)
    begin
      // Direct mode always begins from zero
      if (mode == CSPS_DIRECT)
        phase <= CSPS_PHASE_RST;
      else
        phase <= phase_init;
      overflow <= 1'b0;
      busy <= 1'b0;
      done_armed <= 1'b0;
      adjust_complete <= 1'b0;
    end
    else if (adj_edge)
    begin
      // Pulse lasts exactly one adjust period, edge to edge
      adjust_complete <= done_armed;
      if (done_armed)
      begin
        done_armed <= 1'b0;
        busy <= 1'b0;
      end
      else if (req_s3 && !busy && run && mode != CSPS_FIXED)
      begin
        busy <= 1'b1;
        // At a limit the step is refused but still answered
        if (!phase_ok(next_phase, mode)
            || shift_of(next_phase, mode, period) > line_lim
            || shift_of(next_phase, mode, period) < -line_lim)
          overflow <= 1'b1;
        else
        begin
          phase <= next_phase;
          overflow <= 1'b0;
        end
      end
    end
    else if (busy && !done_armed && applied == target)
      done_armed <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Delay line: shift walks one cycle at a time toward its target

  // Positive shift holds the base counter (delay in feedback path),
  // negative shift skips ahead (delay in reference path)
  always_comb
  begin
    adv = 2'd1;
    if (applied < target)
      adv = 2'd0;
    else if (applied > target)
      adv = 2'd2;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      applied <= 18'sh0;
      pos <= 16'h0000;
    end
    else if (!run)
    begin
      applied <= 18'sh0;
      pos <= 16'h0000;
    end
    else
    begin
      if (adv == 2'd0)
        applied <= applied + 18'sh1;
      else if (adv == 2'd2)
        applied <= applied - 18'sh1;
      // Base step shared by every output counter, so all move together
      if (16'(pos + 16'(adv)) >= period)
        pos <= 16'(pos + 16'(adv) - period);
      else
        pos <= 16'(pos + 16'(adv));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Divided and synthesised outputs, advanced by the same base steps

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_cnt <= 21'h0;
      divided_out <= 1'b0;
    end
    else if (!run)
    begin
      div_cnt <= 21'h0;
      divided_out <= 1'b0;
    end
    else if (div_cnt + 21'(adv) >= div_half)
    begin
      div_cnt <= 21'(div_cnt + 21'(adv) - div_half);
      divided_out <= ~divided_out;
    end
    else
      div_cnt <= 21'(div_cnt + 21'(adv));
  end

  // Accumulator toggles every P*D/(2M) cycles: equal halves, ratio M/D
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      synth_acc <= 24'h0;
      synth_out <= 1'b0;
      synth_out_inv <= 1'b1;
      ref_cycles <= 8'h00;
    end
    else if (!run)
    begin
      synth_acc <= 24'h0;
      synth_out <= 1'b0;
      synth_out_inv <= 1'b1;
      ref_cycles <= 8'h00;
    end
    else if (adv != 2'd0 && 16'(pos + 16'(adv)) >= period && fb_en
             && ref_cycles == 8'(divisor - 8'h01))
    begin
      // Realign to the phase0 rising edge every D input periods
      ref_cycles <= 8'h00;
      synth_acc <= 24'h0;
      synth_out <= 1'b1;
      synth_out_inv <= 1'b0;
    end
    else
    begin
      if (adv != 2'd0 && 16'(pos + 16'(adv)) >= period)
        ref_cycles <= 8'(ref_cycles + 8'h01);
      if (synth_acc + 24'({mult, 1'b0}) * 24'(adv) >= synth_lim)
      begin
        synth_acc <= 24'(synth_acc + 24'({mult, 1'b0}) * 24'(adv)
                         - synth_lim);
        synth_out <= ~synth_out;
        synth_out_inv <= synth_out;
      end
      else
        synth_acc <= 24'(synth_acc + 24'({mult, 1'b0}) * 24'(adv));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Coarse phases and double rate, decoded from the base counter

  // Decoded from one counter, so relations hold with or without feedback
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase0_out <= 1'b0;
      phase90_out <= 1'b0;
      phase180_out <= 1'b0;
      phase270_out <= 1'b0;
      double_rate_out <= 1'b0;
      double_rate_out_inv <= 1'b0;
    end
    else if (!run)
    begin
      phase0_out <= 1'b0;
      phase90_out <= 1'b0;
      phase180_out <= 1'b0;
      phase270_out <= 1'b0;
      double_rate_out <= 1'b0;
      double_rate_out_inv <= 1'b0;
    end
    else
    begin
      phase0_out <= pos < (q << 1);
      phase90_out <= pos >= q && pos < 16'(q * 16'd3);
      phase180_out <= pos >= (q << 1);
      phase270_out <= pos < q || pos >= 16'(q * 16'd3);
      double_rate_out <= pos < q
                         || (pos >= (q << 1) && pos < 16'(q * 16'd3));
      double_rate_out_inv <= !(pos < q
                         || (pos >= (q << 1) && pos < 16'(q * 16'd3)));
    end
  end

endmodule

// [verification/csps_properties.sv]
// Checker: port-level properties of the clock manager
`timescale 1ns/1ps

module csps_properties
(
  // APB handshake
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Adjust link
  input wire logic adjust_clock,
  input wire logic adjust_complete,
  // Generated clocks
  input wire logic phase0_out,
  input wire logic phase90_out,
  input wire logic phase180_out,
  input wire logic phase270_out,
  input wire logic double_rate_out,
  input wire logic double_rate_out_inv,
  input wire logic synth_out,
  input wire logic synth_out_inv
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic adj_q;
  logic [3:0] adj_edges;

  ////////////////////////////////////////////////////////////////////////
  // Adjust edges seen while completion is high; one flop suffices
  // because the pulse lags its launching edge by more than that
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      adj_q <= 1'b0;
      adj_edges <= 4'h0;
    end
    else
    begin
      adj_q <= adjust_clock;
      if (!adjust_complete)
        adj_edges <= 4'h0;
      else if (adjust_clock && !adj_q)
        adj_edges <= adj_edges + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Access phase and its single wait state
  sequence s_access_start;
    psel && $rose(penable);
  endsequence

  sequence s_one_wait;
    !pready ##1 pready;
  endsequence

  a_one_wait_state: assert property (s_access_start |-> s_one_wait)
    else $error("ready not one cycle after access start");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("ready outside an access phase");
  a_error_with_ready: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  a_synth_twin: assert property (synth_out_inv != synth_out)
    else $error("synth pair not complementary");
  a_double_apart: assert property (
    double_rate_out |-> !double_rate_out_inv)
    else $error("double rate pair both high");
  a_coarse_apart: assert property (
    !(phase0_out && phase180_out) && !(phase90_out && phase270_out))
    else $error("opposite coarse phases both high");
  a_quarter_order: assert property ($rose(phase90_out) |-> phase0_out)
    else $error("quarter phase rose outside first half");
  a_complete_one: assert property (
    $fell(adjust_complete) |-> adj_edges == 4'h1)
    else $error("completion not one adjust period");
endmodule

bind csps_clock_manager csps_properties u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .adjust_clock(adjust_clock),
  .adjust_complete(adjust_complete), .phase0_out(phase0_out),
  .phase90_out(phase90_out), .phase180_out(phase180_out),
  .phase270_out(phase270_out), .double_rate_out(double_rate_out),
  .double_rate_out_inv(double_rate_out_inv), .synth_out(synth_out),
  .synth_out_inv(synth_out_inv)
);

// [verification/csps_adjust_user.sv]
// Partner model: user logic stepping the fine phase over the adjust link
`timescale 1ns/1ps

module csps_adjust_user
(
  // Adjust link
  output logic adjust_clock,
  output logic adjust_request,
  output logic adjust_direction,
  input wire logic adjust_complete
);
  ////////////////////////////////////////////////////////////////////////
  // Free-running 12.5 MHz, well below a quarter of pclk
  initial
  begin
    adjust_clock = 1'b0;
    adjust_request = 1'b0;
    adjust_direction = 1'b1;
  end

  always #40 adjust_clock = ~adjust_clock;

  // One step; got tells whether completion came within the bound
  task automatic step(input logic dir, output logic got);
    int n;
  begin
    n = 0;
    got = 1'b0;
    @(posedge adjust_clock);
    adjust_request <= 1'b1;
    adjust_direction <= dir;
    @(posedge adjust_clock);
    adjust_request <= 1'b0;
    // Direction no longer qualified, so show the other level
    adjust_direction <= ~dir;
    while (!got && n < 100)
    begin
      @(posedge adjust_clock);
      n++;
      got = (adjust_complete === 1'b1);
    end
  end
  endtask
endmodule

// [verification/testbench.sv]
// Testbench: registers, output rates and fine phase stepping
`timescale 1ns/1ps

module testbench;
  import csps_pkg::*;

  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, adjust_complete;
  logic adjust_clock, adjust_request, adjust_direction;
  logic phase0_out, phase90_out, phase180_out, phase270_out;
  logic double_rate_out, double_rate_out_inv, divided_out;
  logic synth_out, synth_out_inv;
  int fails = 0;
  int n_tests = 0;
  int cycles = 0;

  always #5 pclk = ~pclk;

  csps_clock_manager u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .adjust_clock(adjust_clock),
    .adjust_request(adjust_request), .adjust_direction(adjust_direction),
    .adjust_complete(adjust_complete), .phase0_out(phase0_out),
    .phase90_out(phase90_out), .phase180_out(phase180_out),
    .phase270_out(phase270_out), .double_rate_out(double_rate_out),
    .double_rate_out_inv(double_rate_out_inv), .divided_out(divided_out),
    .synth_out(synth_out), .synth_out_inv(synth_out_inv)
  );

  csps_adjust_user u_user (
    .adjust_clock(adjust_clock), .adjust_request(adjust_request),
    .adjust_direction(adjust_direction), .adjust_complete(adjust_complete)
  );

  ////////////////////////////////////////////////////////////////////////
  task automatic bad(input string msg);
  begin
    fails++;
    $display("BAD %0t %s", $time, msg);
  end
  endtask

  task automatic tally_and_finish;
  begin
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end
  endtask

  // Hang guard, well above the expected run length
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      bad("timeout");
      tally_and_finish;
    end
  end

  // One APB transfer; held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] wd, output logic [31:0] rd, output logic err);
    int n;
  begin
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 16)
    begin
      @(posedge pclk);
      n++;
    end
    if (n == 16)
      bad("no ready");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
  begin
    apb(1'b1, a, d, rd, err);
  end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
    input logic exp_err);
    logic [31:0] rd;
    logic err;
  begin
    apb(1'b0, a, 32'h0, rd, err);
    n_tests++;
    if (err !== exp_err || (!exp_err && rd !== exp))
      bad($sformatf("read %h got %h want %h", a, rd, exp));
  end
  endtask

  // Status word while running and idle
  function automatic logic [31:0] st(input logic ovf, input logic [10:0] ph);
    return {13'h0, 1'b0, 1'b1, ovf, 5'h0, ph};
  endfunction

  function automatic logic near(input int got, input int exp);
    return got >= exp - 1 && got <= exp + 1;
  endfunction

  task automatic step_chk(input logic dir, input logic exp_done,
    input logic ovf, input logic [10:0] ph);
    logic got;
  begin
    u_user.step(dir, got);
    n_tests++;
    if (got !== exp_done)
      bad("completion pulse");
    rd_chk(CSPS_STATUS_OFS, st(ovf, ph), 1'b0);
  end
  endtask

  // Stop, choose mode, load setting, run; feedback kept connected
  task automatic start_mode(input logic [1:0] md, input logic [10:0] ph);
  begin
    wr(CSPS_CTRL_OFS, 32'h4);
    wr(CSPS_CTRL_OFS, {29'h0, 1'b1, md});
    wr(CSPS_PHASE_OFS, {21'h0, ph});
    wr(CSPS_CTRL_OFS, {28'h0, 2'b11, md});
  end
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_registers;
  begin
    rd_chk(CSPS_CTRL_OFS, 32'h0, 1'b0);
    rd_chk(CSPS_PERIOD_OFS, 32'h10, 1'b0);
    rd_chk(CSPS_DIVIDE_OFS, 32'h4, 1'b0);
    rd_chk(CSPS_SYNTH_OFS, 32'h0101, 1'b0);
    rd_chk(CSPS_PHASE_OFS, 32'h0, 1'b0);
    wr(CSPS_STATUS_OFS, 32'hFFFFFFFF);
    rd_chk(CSPS_STATUS_OFS, 32'h0, 1'b0);
    rd_chk(8'h18, 32'h0, 1'b1);
  end
  endtask

  // Edge counts over 144 input periods of 16 cycles, M/D = 3/2
  task automatic t_rates(input logic [5:0] code, input int exp_div);
    int n0, n2, nd, nf, hi;
    logic p0, p2, pd, pf;
  begin
    wr(CSPS_CTRL_OFS, 32'h4);
    wr(CSPS_DIVIDE_OFS, {26'h0, code});
    rd_chk(CSPS_DIVIDE_OFS, {26'h0, code}, 1'b0);
    wr(CSPS_SYNTH_OFS, 32'h0203);
    wr(CSPS_CTRL_OFS, 32'hC);
    repeat (64) @(negedge pclk);
    {n0, n2, nd, nf, hi} = '0;
    {p0, p2, pd, pf} = {phase0_out, double_rate_out, divided_out, synth_out};
    repeat (2304)
    begin
      @(negedge pclk);
      if (phase0_out === 1'b1 && !p0) n0++;
      if (double_rate_out === 1'b1 && !p2) n2++;
      if (divided_out === 1'b1 && !pd) nd++;
      if (synth_out === 1'b1 && !pf) nf++;
      if (synth_out === 1'b1) hi++;
      {p0, p2, pd, pf} = {phase0_out, double_rate_out, divided_out, synth_out};
    end
    n_tests += 5;
    if (!near(n0, 144)) bad("input rate");
    if (!near(n2, 288)) bad("double rate");
    if (!near(nd, exp_div)) bad("divided rate");
    if (!near(nf, 216)) bad("synth rate");
    if (hi < 1140 || hi > 1164) bad("synth duty");
  end
  endtask

  task automatic t_phase_modes;
  begin
    // Centre mode: climb to the top, refuse one more, come back
    start_mode(2'd1, 11'h0FE);
    rd_chk(CSPS_STATUS_OFS, st(1'b0, 11'h0FE), 1'b0);
    step_chk(1'b1, 1'b1, 1'b0, 11'h0FF);
    step_chk(1'b1, 1'b1, 1'b1, 11'h0FF);
    step_chk(1'b0, 1'b1, 1'b0, 11'h0FE);
    // Direct mode ignores the loaded setting and stays non-negative
    start_mode(2'd3, 11'h005);
    rd_chk(CSPS_STATUS_OFS, st(1'b0, 11'h000), 1'b0);
    step_chk(1'b0, 1'b1, 1'b1, 11'h000);
    step_chk(1'b1, 1'b1, 1'b0, 11'h001);
    // Positive mode refuses negative and oversized settings silently
    wr(CSPS_CTRL_OFS, 32'h4);
    wr(CSPS_CTRL_OFS, 32'h6);
    wr(CSPS_PHASE_OFS, 32'h7FF);
    rd_chk(CSPS_PHASE_OFS, 32'h005, 1'b0);
    wr(CSPS_PHASE_OFS, 32'h100);
    rd_chk(CSPS_PHASE_OFS, 32'h005, 1'b0);
    start_mode(2'd2, 11'h0FF);
    step_chk(1'b1, 1'b1, 1'b1, 11'h0FF);
    // Fixed mode: lowest setting held, steps and rewrites ignored
    start_mode(2'd0, 11'h701);
    rd_chk(CSPS_STATUS_OFS, st(1'b0, 11'h701), 1'b0);
    step_chk(1'b1, 1'b0, 1'b0, 11'h701);
    wr(CSPS_PHASE_OFS, 32'h3);
    rd_chk(CSPS_STATUS_OFS, st(1'b0, 11'h701), 1'b0);
    // Long period: centre line limit hit, then doubled by max range
    wr(CSPS_CTRL_OFS, 32'h4);
    wr(CSPS_PERIOD_OFS, 32'h400);
    start_mode(2'd1, 11'h080);
    step_chk(1'b1, 1'b1, 1'b1, 11'h080);
    wr(CSPS_CTRL_OFS, 32'h4);
    wr(CSPS_CTRL_OFS, 32'h1D);
    rd_chk(CSPS_CTRL_OFS, 32'h1D, 1'b0);
    step_chk(1'b1, 1'b1, 1'b0, 11'h081);
  end
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (16) @(posedge pclk);
    n_tests++;
    if (phase0_out !== 1'b0 || synth_out_inv !== 1'b1)
      bad("reset levels");
    presetn <= 1'b1;
    t_registers;
    t_rates(6'd3, 96);
    t_rates(6'd16, 18);
    t_rates(6'd18, 16);
    t_rates(6'd32, 9);
    t_phase_modes;
    tally_and_finish;
  end
endmodule
